// ---- rtl/supervisor_pkg.sv ----
// constants and timing for the supervisor reset and watchdog block
// ----------------------------------------------------------------
// Behaviour
// - reset_o is always the exact inverse of reset_n_o.
// - hold reset while supply low, release about 200 ms after recovery.
// - assert reset at once when supply-low indication goes active.
// - brownout gives a reset pulse; a running pulse lasts 140 ms at least.
// - power_fail_flag_n low whenever comparator reports input below trip.
// - manual_reset_n low starts a reset pulse of 140 ms minimum.
// - no kick edge within 1.6 s of counting drives watchdog_expired_n low.
// - expired output stays low until a new kick edge is seen.
// - kick input floating keeps watchdog counter cleared and stopped.
// - watchdog counter is held cleared while reset is asserted.
// - after reset, any kick edge starts a fresh 1.6 s countdown.
// - every further kick edge clears counter and restarts countdown.
// - expired output forced low while supply low, high again at once.
// - reset stays asserted 200 ms after manual_reset_n returns high.
// - watchdog expiry does not assert reset by itself.
// ----------------------------------------------------------------
package supervisor_pkg;
    // core clock period in picoseconds (20 MHz)
    localparam longint CLK_PERIOD_PS = 64'd50_000;
    // reset stretch, typical, in milliseconds
    localparam longint RESET_STRETCH_MS = 64'd200;
    // watchdog timeout in milliseconds
    localparam longint WDOG_TIMEOUT_MS = 64'd1600;
    // cycle counts derived from the clock rate
    localparam longint RESET_STRETCH_CYC = (RESET_STRETCH_MS * 64'd1_000_000_000)
        / CLK_PERIOD_PS;
    localparam longint WDOG_TIMEOUT_CYC = (WDOG_TIMEOUT_MS * 64'd1_000_000_000)
        / CLK_PERIOD_PS;
    // counter width, wide enough for either default
    localparam int CNT_W = 32;
    // values after reset
    localparam logic RESET_N_RST = 1'b0;
    localparam logic EXPIRED_N_RST = 1'b1;
    // synchroniser order {float, kick, manual_n, sense, supply_low}
    localparam logic [4:0] SYNC_RST = 5'h05;
    localparam logic KICK_PREV_RST = 1'b0;
    localparam logic FAIL_FLAG_N_RST = 1'b1;
endpackage

// ---- rtl/supervisor_reset_watchdog.sv ----
// reset stretcher, watchdog and power-fail flag for a supervised processor
`timescale 1ns/1ps
module supervisor_reset_watchdog #(
    parameter logic [31:0] STRETCH_CYC = 32'(supervisor_pkg::RESET_STRETCH_CYC),
    parameter logic [31:0] WDOG_CYC = 32'(supervisor_pkg::WDOG_TIMEOUT_CYC)
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // supply and comparator indications
    input wire logic supply_low_i,
    input wire logic power_fail_sense_in_i,
    // manual reset and watchdog kick
    input wire logic manual_reset_n_i,
    input wire logic watchdog_kick_in_i,
    input wire logic kick_float_i,
    // outputs to the processor
    output logic reset_n_o,
    output logic reset_o,
    output logic watchdog_expired_n_o,
    output logic power_fail_flag_n_o
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // a zero stretch would let reset drop while the trigger still settles
    if (STRETCH_CYC < 32'd1 || WDOG_CYC < 32'd2) begin : g_bad_param
        $error("supervisor counts too small");
    end
    // counters below are fixed at 32 bits
    if (supervisor_pkg::CNT_W != 32) begin : g_bad_width
        $error("supervisor counter width must be 32");
    end
    // the package cycle counts are cut to 32 bits for the defaults
    if (supervisor_pkg::RESET_STRETCH_CYC > 64'hFFFF_FFFF ||
        supervisor_pkg::WDOG_TIMEOUT_CYC > 64'hFFFF_FFFF) begin : g_bad_default
        $error("supervisor default counts overflow");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] raw_in;
    logic supply_low_s;
    logic sense_below_s;
    logic manual_n_s;
    logic kick_s;
    logic float_s;

    // all pins are asynchronous to the core clock, so they travel together
    assign raw_in = {kick_float_i, watchdog_kick_in_i, manual_reset_n_i,
                     power_fail_sense_in_i, supply_low_i};
    // only the second stage is read beyond this point
    assign supply_low_s = sync2_r[0];
    assign sense_below_s = sync2_r[1];
    assign manual_n_s = sync2_r[2];
    assign kick_s = sync2_r[3];
    assign float_s = sync2_r[4];

    // two stages; reset values read as supply low so reset cannot drop early
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_r <= supervisor_pkg::SYNC_RST;
            sync2_r <= supervisor_pkg::SYNC_RST;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    // ------------------------------------------------------------
    // kick edge detector
    // ------------------------------------------------------------
    logic kick_prev_r;
    logic kick_prev_nxt;
    logic kick_edge;

    // either polarity counts; a pulse shorter than a clock may be missed
    assign kick_edge = kick_s ^ kick_prev_r;

    always_comb begin
        kick_prev_nxt = kick_s; // tracks the pin even while disabled
    end

    // reset level matches a low idle pin, so no false edge after reset
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            kick_prev_r <= supervisor_pkg::KICK_PREV_RST;
        end else begin
            kick_prev_r <= kick_prev_nxt;
        end
    end

    // ------------------------------------------------------------
    // reset stretcher
    // ------------------------------------------------------------
    logic [31:0] rst_cnt_r;
    logic [31:0] rst_cnt_nxt;
    logic reset_n_r;
    logic reset_n_nxt;
    logic trigger;

    // supply low or manual reset keep the counter reloaded
    assign trigger = supply_low_s || !manual_n_s;

    // any trigger reloads, so a brownout mid-pulse restarts the full stretch
    always_comb begin
        rst_cnt_nxt = rst_cnt_r;
        reset_n_nxt = reset_n_r;
        if (trigger) begin
            rst_cnt_nxt = STRETCH_CYC;
            reset_n_nxt = 1'b0;
        end else if (rst_cnt_r != 32'd0) begin
            rst_cnt_nxt = rst_cnt_r - 32'd1;
            reset_n_nxt = 1'b0;
        end else begin
            reset_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_cnt_r <= STRETCH_CYC;
            reset_n_r <= supervisor_pkg::RESET_N_RST;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            reset_n_r <= reset_n_nxt;
        end
    end

    assign reset_n_o = reset_n_r;
    assign reset_o = ~reset_n_r;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic [31:0] wd_cnt_r;
    logic [31:0] wd_cnt_nxt;
    logic wd_run_r;
    logic wd_run_nxt;
    logic expired_r;
    logic expired_nxt;

    // counting starts only after an edge seen outside reset
    always_comb begin
        wd_cnt_nxt = wd_cnt_r;
        wd_run_nxt = wd_run_r;
        expired_nxt = expired_r;
        if (float_s || !reset_n_r) begin
            wd_cnt_nxt = 32'd0;
            wd_run_nxt = 1'b0;
        end else if (kick_edge) begin
            wd_cnt_nxt = 32'd0;
            wd_run_nxt = 1'b1;
            expired_nxt = 1'b0;
        end else if (wd_run_r) begin
            if (wd_cnt_r >= WDOG_CYC - 32'd1) begin
                expired_nxt = 1'b1;
                wd_run_nxt = 1'b0;
            end else begin
                wd_cnt_nxt = wd_cnt_r + 32'd1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wd_cnt_r <= 32'd0;
            wd_run_r <= 1'b0;
            expired_r <= 1'b0;
        end else begin
            wd_cnt_r <= wd_cnt_nxt;
            wd_run_r <= wd_run_nxt;
            expired_r <= expired_nxt;
        end
    end

    // ------------------------------------------------------------
    // expiry output
    // ------------------------------------------------------------
    logic expired_n_r;
    logic expired_n_nxt;

    // supply gate has no stretch, unlike the reset outputs
    always_comb begin
        expired_n_nxt = !(expired_nxt || supply_low_s);
    end

    // registered so the pin never shows a decode glitch
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            expired_n_r <= supervisor_pkg::EXPIRED_N_RST;
        end else begin
            expired_n_r <= expired_n_nxt;
        end
    end

    assign watchdog_expired_n_o = expired_n_r;

    // ------------------------------------------------------------
    // power-fail flag
    // ------------------------------------------------------------
    logic fail_flag_n_r;
    logic fail_flag_n_nxt;

    // comparator result passes straight through; hysteresis stays off chip
    always_comb begin
        fail_flag_n_nxt = !sense_below_s;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fail_flag_n_r <= supervisor_pkg::FAIL_FLAG_N_RST;
        end else begin
            fail_flag_n_r <= fail_flag_n_nxt;
        end
    end

    assign power_fail_flag_n_o = fail_flag_n_r;

endmodule

// ---- bench/supervisor_sva.sv ----
// assertion checker for the supervisor block
`timescale 1ns/1ps
module supervisor_sva (
    // clock, reset and inputs
    input wire logic core_clk_i, nrst_i, supply_low_i, power_fail_sense_in_i,
    input wire logic manual_reset_n_i, watchdog_kick_in_i, kick_float_i,
    // outputs
    input wire logic reset_n_o, reset_o, watchdog_expired_n_o, power_fail_flag_n_o
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_INV: assert property (reset_o != reset_n_o)
        else $error("reset pair not inverse");
    AST_PF: assert property (power_fail_sense_in_i[*5] |-> !power_fail_flag_n_o)
        else $error("flag not low");
    AST_SUP: assert property (supply_low_i[*5] |-> !reset_n_o)
        else $error("no reset on low supply");
    AST_MANUAL: assert property ((!manual_reset_n_i)[*5] |-> !reset_n_o)
        else $error("no manual reset");
    AST_SUP_HOLD: assert property (
        supply_low_i[*4] ##1 !supply_low_i |-> !reset_n_o[*8]) else $error("short stretch");
    AST_MANUAL_HOLD: assert property (
        (!manual_reset_n_i)[*4] ##1 manual_reset_n_i |-> !reset_n_o[*8])
        else $error("short stretch");
    AST_WDO_LOW: assert property (supply_low_i[*5] |-> !watchdog_expired_n_o)
        else $error("expiry not forced");
    AST_EXP_KEEP: assert property (
        (!supply_low_i && $stable(watchdog_kick_in_i))[*6] ##0 !watchdog_expired_n_o
        |=> !watchdog_expired_n_o) else $error("expiry lost");
    // main scenarios reached
    cover property ($rose(reset_n_o));
    cover property ($fell(watchdog_expired_n_o) && reset_n_o);
    cover property ($fell(power_fail_flag_n_o));
endmodule

// ---- bench/kick_driver.sv ----
// processor model that kicks the watchdog or lets its pin float
`timescale 1ns/1ps
module kick_driver (
    // clock and commands
    input wire logic core_clk_i,
    input wire logic run_i,
    input wire logic step_i,
    input wire logic float_i,
    // kick pin and float indication
    output logic kick_o,
    output logic float_o
);
    int cnt;
    logic float_d;
    initial begin
        cnt = 0;
        float_d = 1'b0;
        kick_o = 1'b0;
        float_o = 1'b0;
    end
    // a released pin settles at the inverse of its last level and then holds,
    // so a watchdog that ignored the float indication would time out
    always @(posedge core_clk_i) begin
        cnt <= (run_i && cnt < 20) ? cnt + 1 : 0;
        float_d <= float_i;
        if (step_i || (run_i && cnt == 20) || (float_i && !float_d)) begin
            kick_o <= #1 ~kick_o;
        end
        float_o <= #1 float_i;
    end
endmodule

// ---- bench/tb_supervisor_reset_watchdog.sv ----
// self-checking bench for the supervisor block
`timescale 1ns/1ps
module tb_supervisor_reset_watchdog;
    localparam int ST = 20;
    localparam int WD = 50;
    logic core_clk_i = 0, nrst_i = 0, supply_low_i = 0, power_fail_sense_in_i = 0;
    logic manual_reset_n_i = 1, run = 0, step = 0, flt = 0;
    logic watchdog_kick_in_i, kick_float_i, reset_n_o, reset_o;
    logic watchdog_expired_n_o, power_fail_flag_n_o;
    integer seed = 32'h64e66bdf;
    int err_count = 0, comparisons = 0, n;
    always #25 core_clk_i = ~core_clk_i;
    kick_driver u_kick_driver (.core_clk_i, .run_i(run), .step_i(step), .float_i(flt),
        .kick_o(watchdog_kick_in_i), .float_o(kick_float_i));
    supervisor_reset_watchdog #(.STRETCH_CYC(32'd20), .WDOG_CYC(32'd50))
        u_supervisor_reset_watchdog (.core_clk_i, .nrst_i, .supply_low_i,
        .power_fail_sense_in_i, .manual_reset_n_i, .watchdog_kick_in_i, .kick_float_i,
        .reset_n_o, .reset_o, .watchdog_expired_n_o, .power_fail_flag_n_o);
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // reference model from the rules: pins reach the logic two edges late
    logic [2:0] hist_q[$];
    logic [2:0] seen;
    int m_cnt = ST;
    logic m_rst_n = 0, m_pf_n = 1;
    always @(posedge core_clk_i) begin
        if (!nrst_i) begin
            hist_q = '{3'h5, 3'h5};
            m_cnt = ST;
            m_rst_n = 0;
            m_pf_n = 1;
        end else begin
            hist_q.push_back({supply_low_i, power_fail_sense_in_i, manual_reset_n_i});
            seen = hist_q.pop_front();
            m_pf_n = !seen[1];
            if (seen[2] || !seen[0]) begin
                m_cnt = ST;
                m_rst_n = 0;
            end else if (m_cnt > 0) begin
                m_cnt--;
                m_rst_n = 0;
            end else begin
                m_rst_n = 1;
            end
        end
    end
    // outputs are settled by the falling edge
    always @(negedge core_clk_i) begin
        chk(reset_n_o, m_rst_n);
        chk(reset_o, !m_rst_n);
        chk(power_fail_flag_n_o, m_pf_n);
    end
    // bounded wait for reset release, then the stretch length is judged
    task automatic rel(input int lo);
        for (n = 0; reset_n_o !== 1'b1 && n < 200; n++) cyc(1);
        chk(n >= lo && n <= ST + 5, 1'b1);
    endtask
    task automatic kick();
        step = 1;
        cyc(1);
        step = 0;
    endtask
    task automatic finish_test();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog span is well beyond the roughly 600 cycles the tests take
    initial begin
        repeat (6000) @(posedge core_clk_i);
        err_count++;
        finish_test();
    end
    initial begin
        cyc(3);
        nrst_i = 1;
        rel(ST);
        $display("test power_up done");
        repeat (16) begin
            power_fail_sense_in_i = 1'($random(seed));
            cyc(4);
            chk(power_fail_flag_n_o, !power_fail_sense_in_i);
        end
        $display("test power_fail done");
        kick();
        manual_reset_n_i = 0;
        cyc(4);
        chk(reset_o, 1);
        cyc(WD + 20);
        chk(watchdog_expired_n_o, 1);
        manual_reset_n_i = 1;
        rel(ST);
        manual_reset_n_i = 0;
        cyc(4);
        manual_reset_n_i = 1;
        cyc(6);
        supply_low_i = 1;
        cyc(4);
        chk(watchdog_expired_n_o, 0);
        chk(reset_n_o, 0);
        supply_low_i = 0;
        cyc(14);
        chk(reset_n_o, 0);
        chk(watchdog_expired_n_o, 1);
        rel(0);
        supply_low_i = 1;
        cyc(4);
        chk(reset_n_o, 0);
        chk(watchdog_expired_n_o, 0);
        supply_low_i = 0;
        cyc(4);
        chk(watchdog_expired_n_o, 1);
        chk(reset_n_o, 0);
        rel(ST - 5);
        $display("test resets done");
        run = 1;
        cyc(200);
        run = 0;
        chk(watchdog_expired_n_o, 1);
        kick();
        for (n = 0; watchdog_expired_n_o !== 1'b0 && n < 200; n++) cyc(1);
        chk(n >= WD && n <= WD + 8, 1'b1);
        cyc(20);
        chk(watchdog_expired_n_o, 0);
        chk(reset_n_o, 1);
        kick();
        cyc(6);
        chk(watchdog_expired_n_o, 1);
        flt = 1;
        cyc(WD + 20);
        chk(watchdog_expired_n_o, 1);
        $display("test watchdog done");
        finish_test();
    end
endmodule
bind supervisor_reset_watchdog supervisor_sva u_sva (.core_clk_i, .nrst_i, .supply_low_i,
    .power_fail_sense_in_i, .manual_reset_n_i, .watchdog_kick_in_i, .kick_float_i,
    .reset_n_o, .reset_o, .watchdog_expired_n_o, .power_fail_flag_n_o);
